// file: core/psi_status_irq.sv
// packet status bytes, instant signal level and event flag command handling
`timescale 1ns/1ps
module psi_status_irq (
   // clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   // command port, byte stream from the transport
   input  wire logic                 frame_start,
   input  wire logic                 cmd_byte_valid,
   input  wire logic [7:0]           cmd_byte,
   input  wire logic                 uart_mode,
   input  wire logic [7:0]           radio_status,
   // radio configuration
   input  wire psi_pkg::psi_ptype_e  packet_type,
   input  wire logic                 rx_active,
   input  wire logic                 dynamic_length,
   input  wire logic                 sync_detect_en,
   input  wire logic                 checksum_en,
   input  wire logic                 long_preamble_option,
   // packet controller events
   input  wire logic                 pkt_op_start,
   input  wire logic                 packet_engine_busy,
   input  wire logic                 packet_tx_finished,
   input  wire logic                 header_seen_flag,
   input  wire logic                 received_no_ack_bit,
   input  wire logic                 sync_result_strobe,
   input  wire logic [2:0]           matched_sync_index,
   input  wire logic                 oversize_length_fail,
   input  wire logic                 checksum_fail_flag,
   input  wire logic                 packet_aborted_flag,
   input  wire logic                 rx_finished_flag,
   // signal level measurement
   input  wire logic signed [9:0]    power_half_dbm,
   input  wire logic                 sample_strobe,
   input  wire logic                 symbol_strobe,
   // event sources, one-cycle pulses
   input  wire logic                 transmit_finished_event,
   input  wire logic                 receive_finished_event,
   input  wire logic                 sync_match_event,
   input  wire logic                 sync_mismatch_event,
   input  wire logic                 header_ok_event,
   input  wire logic                 header_bad_event,
   input  wire logic                 checksum_bad_event,
   input  wire logic                 responder_reply_finished,
   input  wire logic                 responder_request_dropped,
   input  wire logic                 ranging_result_event,
   input  wire logic                 initiator_timed_out,
   input  wire logic                 responder_request_ok,
   input  wire logic                 activity_check_finished,
   input  wire logic                 activity_found,
   input  wire logic                 radio_op_timeout,
   input  wire logic                 preamble_found_event,
   input  wire logic                 advanced_ranging_event,
   // answer byte for the next frame position
   output logic [7:0]                resp_byte_r,
   // packet status bytes and level
   output logic [7:0]                pkt_status_byte_r,
   output logic [7:0]                pkt_error_byte_r,
   output logic [7:0]                pkt_sync_byte_r,
   output logic [7:0]                instant_signal_level_r,
   // flags and event pins
   output logic [15:0]               interrupt_flag_log_r,
   output logic                      event_pin_one,
   output logic                      event_pin_two,
   output logic                      event_pin_three
);

   typedef enum logic {
      PSI_CMD_OPCODE,
      PSI_CMD_ARGS
   } psi_cmd_e;

   typedef struct packed {
      psi_cmd_e           cmd_state;
      logic [7:0]         opcode;
      logic [3:0]         idx;
      logic [15:0]        flag_snap;
      logic [63:0]        args;
      logic [7:0]         resp;
      logic [15:0]        irq_mask;
      logic [2:0][15:0]   pin_mask;
      logic [7:0]         status_b;
      logic [7:0]         error_b;
      logic [7:0]         sync_b;
      logic [7:0]         level;
   } psi_main_s;

   psi_main_s          st_r;
   psi_main_s          st_nxt;
   logic               clr_go;
   logic [15:0]        clr_bits;
   logic [15:0]        raw_events;
   logic [15:0]        avail;
   logic [15:0]        gated_events;
   logic [15:0]        flags_r;
   logic [15:0]        flags_nxt;
   logic [2:0]         pins;
   logic signed [10:0] neg_power;
   logic [3:0]         nidx;
   logic [3:0]         arg_pos;
   logic [63:0]        args_in;

   // event sources packed into flag positions
   always_comb begin
      raw_events = 16'h0000;
      raw_events[psi_pkg::EV_TX_DONE]   = transmit_finished_event;
      raw_events[psi_pkg::EV_RX_DONE]   = receive_finished_event;
      raw_events[psi_pkg::EV_SYNC_OK]   = sync_match_event;
      raw_events[psi_pkg::EV_SYNC_BAD]  = sync_mismatch_event;
      raw_events[psi_pkg::EV_HDR_OK]    = header_ok_event;
      raw_events[psi_pkg::EV_HDR_BAD]   = header_bad_event;
      raw_events[psi_pkg::EV_CRC_BAD]   = checksum_bad_event;
      raw_events[psi_pkg::EV_RESP_DONE] = responder_reply_finished;
      raw_events[psi_pkg::EV_REQ_DROP]  = responder_request_dropped;
      raw_events[psi_pkg::EV_RESULT_OK] = ranging_result_event;
      raw_events[psi_pkg::EV_INIT_TMO]  = initiator_timed_out;
      raw_events[psi_pkg::EV_REQ_OK]    = responder_request_ok;
      raw_events[psi_pkg::EV_CAD_DONE]  = activity_check_finished;
      raw_events[psi_pkg::EV_CAD_FOUND] = activity_found;
      raw_events[psi_pkg::EV_OP_TMO]    = radio_op_timeout;
      // bit 15 changes meaning in ranging mode
      if (packet_type == psi_pkg::PSI_PT_RANGING) begin
         raw_events[psi_pkg::EV_PREAMBLE] = advanced_ranging_event;
      end else begin
         raw_events[psi_pkg::EV_PREAMBLE] = preamble_found_event;
      end
   end

   // sources that exist for the current packet type
   always_comb begin
      case (packet_type)
         psi_pkg::PSI_PT_GFSK:    avail = psi_pkg::AVAIL_GFSK;
         psi_pkg::PSI_PT_NBFS:    avail = psi_pkg::AVAIL_NBFS;
         psi_pkg::PSI_PT_CHIRP:   avail = psi_pkg::AVAIL_CHIRP;
         psi_pkg::PSI_PT_RANGING: avail = psi_pkg::AVAIL_RANGING;
         psi_pkg::PSI_PT_LE: begin
            avail = psi_pkg::AVAIL_LE;
            avail[psi_pkg::EV_PREAMBLE] = long_preamble_option;
         end
         default:                 avail = 16'h0000;
      endcase
      gated_events = raw_events & avail;
   end

   // derived positions used by the command decoder
   always_comb begin
      nidx      = (st_r.idx == psi_pkg::IDX_LAST) ? st_r.idx : 4'(st_r.idx + 4'h1);
      arg_pos   = uart_mode ? 4'(st_r.idx - psi_pkg::UART_LEN_SKIP) : st_r.idx;
      args_in   = {st_r.args[55:0], cmd_byte};
      neg_power = -11'(power_half_dbm);
   end

   // next state: commands, status bytes and level
   always_comb begin
      st_nxt   = st_r;
      clr_go   = 1'b0;
      clr_bits = 16'h0000;

      // frame start: first answer is the status byte
      if (frame_start) begin
         st_nxt.cmd_state = PSI_CMD_OPCODE;
         st_nxt.idx       = 4'h0;
         st_nxt.args      = 64'h0;
         st_nxt.resp      = radio_status;
      end else if (cmd_byte_valid) begin
         st_nxt.idx  = nidx;
         st_nxt.resp = radio_status;
         case (st_r.cmd_state)
            PSI_CMD_OPCODE: begin
               // snapshot keeps both flag bytes from one instant
               st_nxt.opcode    = cmd_byte;
               st_nxt.flag_snap = flags_r;
               st_nxt.cmd_state = PSI_CMD_ARGS;
            end
            PSI_CMD_ARGS: begin
               // a uart length byte sits at index one and is skipped
               if (!(uart_mode && st_r.idx == psi_pkg::UART_LEN_SKIP)) begin
                  st_nxt.args = args_in;
                  if (st_r.opcode == psi_pkg::OP_CLEAR_EVENT_FLAGS &&
                      arg_pos == psi_pkg::CLEAR_ARG_COUNT) begin
                     clr_go   = 1'b1;
                     clr_bits = args_in[15:0];
                  end
                  if (st_r.opcode == psi_pkg::OP_SET_EVENT_ROUTING &&
                      arg_pos == psi_pkg::ROUTE_ARG_COUNT) begin
                     st_nxt.irq_mask    = args_in[63:48];
                     st_nxt.pin_mask[0] = args_in[47:32];
                     st_nxt.pin_mask[1] = args_in[31:16];
                     st_nxt.pin_mask[2] = args_in[15:0];
                  end
               end
            end
            default: st_nxt.cmd_state = PSI_CMD_OPCODE;
         endcase
         // answer prepared for the next byte position
         if (st_r.cmd_state == PSI_CMD_OPCODE) begin
            st_nxt.resp = radio_status;
         end else if (st_r.opcode == psi_pkg::OP_QUERY_INSTANT_SIGNAL) begin
            st_nxt.resp = (nidx == psi_pkg::IDX_FIRST_DATA) ? st_r.level
                                                            : psi_pkg::BYTE_RST;
         end else if (st_r.opcode == psi_pkg::OP_READ_EVENT_FLAGS) begin
            if (nidx == psi_pkg::IDX_FIRST_DATA) begin
               st_nxt.resp = st_r.flag_snap[15:8];
            end else if (nidx == psi_pkg::IDX_SECOND_DATA) begin
               st_nxt.resp = st_r.flag_snap[7:0];
            end else begin
               st_nxt.resp = psi_pkg::BYTE_RST;
            end
         end else begin
            st_nxt.resp = psi_pkg::BYTE_RST;
         end
      end

      // new packet operation wipes the previous packet's bytes
      if (pkt_op_start) begin
         st_nxt.status_b = psi_pkg::BYTE_RST;
         st_nxt.error_b  = psi_pkg::BYTE_RST;
         st_nxt.sync_b   = psi_pkg::BYTE_RST;
      end
      if (header_seen_flag && rx_active && dynamic_length) begin
         st_nxt.status_b[psi_pkg::ST_NO_ACK_BIT] = received_no_ack_bit;
         st_nxt.error_b[psi_pkg::ER_HEADER_BIT]  = 1'b1;
      end
      if (packet_tx_finished && !rx_active) begin
         st_nxt.status_b[psi_pkg::ST_TX_DONE_BIT] = 1'b1;
      end
      if (sync_result_strobe && rx_active && sync_detect_en) begin
         // only a one-hot code names an address; anything else is a failure
         case (matched_sync_index)
            psi_pkg::SYNC_CODE_ONE,
            psi_pkg::SYNC_CODE_TWO,
            psi_pkg::SYNC_CODE_THREE: begin
               st_nxt.sync_b[psi_pkg::SY_CODE_MSB:0] = matched_sync_index;
               st_nxt.error_b[psi_pkg::ER_SYNC_BIT]  = 1'b0;
            end
            default: begin
               st_nxt.sync_b[psi_pkg::SY_CODE_MSB:0] = psi_pkg::SYNC_CODE_NONE;
               st_nxt.error_b[psi_pkg::ER_SYNC_BIT]  = 1'b1;
            end
         endcase
      end
      if (oversize_length_fail && rx_active && dynamic_length) begin
         st_nxt.error_b[psi_pkg::ER_LENGTH_BIT] = 1'b1;
      end
      // failure is only reported; nothing here discards buffered data
      if (checksum_fail_flag && rx_active && checksum_en) begin
         st_nxt.error_b[psi_pkg::ER_CRC_BIT] = 1'b1;
      end
      if (packet_aborted_flag) begin
         st_nxt.error_b[psi_pkg::ER_ABORT_BIT] = 1'b1;
      end
      if (rx_finished_flag && rx_active) begin
         st_nxt.error_b[psi_pkg::ER_RX_DONE_BIT] = 1'b1;
      end
      st_nxt.error_b[psi_pkg::ER_BUSY_BIT] = packet_engine_busy;
      // reserved positions forced to zero
      st_nxt.status_b[7:6] = 2'b00;
      st_nxt.status_b[4:1] = 4'h0;
      st_nxt.error_b[7]    = 1'b0;
      st_nxt.sync_b[7:3]   = 5'h00;

      // level refresh: per symbol in chirp modes, per sample otherwise
      if ((packet_type == psi_pkg::PSI_PT_CHIRP || packet_type == psi_pkg::PSI_PT_RANGING)
          ? symbol_strobe : sample_strobe) begin
         if (neg_power < 11'sd0) begin
            st_nxt.level = psi_pkg::BYTE_RST;
         end else if (neg_power > 11'sd255) begin
            st_nxt.level = psi_pkg::LEVEL_MAX;
         end else begin
            st_nxt.level = neg_power[7:0];
         end
      end

      // synchronous reset
      if (!rst_n) begin
         st_nxt           = '0;
         st_nxt.cmd_state = PSI_CMD_OPCODE;
         st_nxt.irq_mask  = psi_pkg::MASK_RST;
         st_nxt.pin_mask  = {3{psi_pkg::MASK_RST}};
         st_nxt.resp      = psi_pkg::BYTE_RST;
         st_nxt.status_b  = psi_pkg::BYTE_RST;
         st_nxt.error_b   = psi_pkg::BYTE_RST;
         st_nxt.sync_b    = psi_pkg::BYTE_RST;
         st_nxt.level     = psi_pkg::BYTE_RST;
         clr_go           = 1'b0;
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      st_r <= st_nxt;
   end

   // sticky flag register
   psi_flag_bank u_bank (
      .sys_clk           (sys_clk),
      .rst_n             (rst_n),
      .events            (gated_events),
      .event_enable_mask (st_r.irq_mask),
      .clr_go            (clr_go),
      .clr_bits          (clr_bits),
      .flags_r           (flags_r),
      .flags_nxt         (flags_nxt)
   );

   // three routed event pins
   for (genvar p = 0; p < 3; p++) begin : g_pin
      psi_pin_drive u_pin (
         .sys_clk           (sys_clk),
         .rst_n             (rst_n),
         .flags_nxt         (flags_nxt),
         .event_enable_mask (st_r.irq_mask),
         .pin_mask          (st_r.pin_mask[p]),
         .pin_r             (pins[p])
      );
   end

   // outputs straight from registers
   assign resp_byte_r            = st_r.resp;
   assign pkt_status_byte_r      = st_r.status_b;
   assign pkt_error_byte_r       = st_r.error_b;
   assign pkt_sync_byte_r        = st_r.sync_b;
   assign instant_signal_level_r = st_r.level;
   assign interrupt_flag_log_r   = flags_r;
   assign event_pin_one          = pins[0];
   assign event_pin_two          = pins[1];
   assign event_pin_three        = pins[2];

endmodule : psi_status_irq

// file: core/psi_pkg.sv
// constants and types shared by the packet status and event flag logic
package psi_pkg;

   // packet type selected for the radio
   typedef enum logic [2:0] {
      PSI_PT_GFSK,
      PSI_PT_CHIRP,
      PSI_PT_RANGING,
      PSI_PT_NBFS,
      PSI_PT_LE
   } psi_ptype_e;

   // command opcodes seen on the command port
   localparam logic [7:0]  OP_QUERY_INSTANT_SIGNAL = 8'h1F;
   localparam logic [7:0]  OP_READ_EVENT_FLAGS     = 8'h15;
   localparam logic [7:0]  OP_CLEAR_EVENT_FLAGS    = 8'h97;
   localparam logic [7:0]  OP_SET_EVENT_ROUTING    = 8'h8D;

   // byte positions within a command frame
   localparam logic [3:0]  IDX_FIRST_DATA  = 4'h2;
   localparam logic [3:0]  IDX_SECOND_DATA = 4'h3;
   localparam logic [3:0]  IDX_LAST        = 4'hF;
   localparam logic [3:0]  UART_LEN_SKIP   = 4'h1;
   localparam logic [3:0]  CLEAR_ARG_COUNT = 4'h2;
   localparam logic [3:0]  ROUTE_ARG_COUNT = 4'h8;

   // packet status byte fields
   localparam int          ST_NO_ACK_BIT   = 5;
   localparam int          ST_TX_DONE_BIT  = 0;
   // error byte fields
   localparam int          ER_SYNC_BIT     = 6;
   localparam int          ER_LENGTH_BIT   = 5;
   localparam int          ER_CRC_BIT      = 4;
   localparam int          ER_ABORT_BIT    = 3;
   localparam int          ER_HEADER_BIT   = 2;
   localparam int          ER_RX_DONE_BIT  = 1;
   localparam int          ER_BUSY_BIT     = 0;
   // sync byte field and codes
   localparam int          SY_CODE_MSB     = 2;
   localparam logic [2:0]  SYNC_CODE_NONE  = 3'h0;
   localparam logic [2:0]  SYNC_CODE_ONE   = 3'h1;
   localparam logic [2:0]  SYNC_CODE_TWO   = 3'h2;
   localparam logic [2:0]  SYNC_CODE_THREE = 3'h4;

   // event flag positions
   localparam int          EV_TX_DONE      = 0;
   localparam int          EV_RX_DONE      = 1;
   localparam int          EV_SYNC_OK      = 2;
   localparam int          EV_SYNC_BAD     = 3;
   localparam int          EV_HDR_OK       = 4;
   localparam int          EV_HDR_BAD      = 5;
   localparam int          EV_CRC_BAD      = 6;
   localparam int          EV_RESP_DONE    = 7;
   localparam int          EV_REQ_DROP     = 8;
   localparam int          EV_RESULT_OK    = 9;
   localparam int          EV_INIT_TMO     = 10;
   localparam int          EV_REQ_OK       = 11;
   localparam int          EV_CAD_DONE     = 12;
   localparam int          EV_CAD_FOUND    = 13;
   localparam int          EV_OP_TMO       = 14;
   localparam int          EV_PREAMBLE     = 15;

   // sources that exist for each packet type
   localparam logic [15:0] AVAIL_GFSK      = 16'hC047;
   localparam logic [15:0] AVAIL_NBFS      = 16'h404F;
   localparam logic [15:0] AVAIL_LE        = 16'h4047;
   localparam logic [15:0] AVAIL_CHIRP     = 16'hF173;
   localparam logic [15:0] AVAIL_RANGING   = 16'hFFB0;

   // values after reset, and the saturated level ceiling
   localparam logic [15:0] FLAGS_RST       = 16'h0000;
   localparam logic [15:0] MASK_RST        = 16'h0000;
   localparam logic [7:0]  BYTE_RST        = 8'h00;
   localparam logic [7:0]  LEVEL_MAX       = 8'hFF;

endpackage : psi_pkg

// file: core/psi_flag_bank.sv
// sixteen sticky event flags with enable gating and clear by mask
`timescale 1ns/1ps
module psi_flag_bank (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // event pulses and enables
   input  wire logic [15:0] events,
   input  wire logic [15:0] event_enable_mask,
   // clear request
   input  wire logic        clr_go,
   input  wire logic [15:0] clr_bits,
   // flag state
   output logic      [15:0] flags_r,
   output logic      [15:0] flags_nxt
);

   typedef struct packed {
      logic [15:0] flags;
   } psi_bank_s;

   psi_bank_s st_r;
   psi_bank_s st_nxt;

   // hold until cleared; a set in the clear cycle wins
   always_comb begin
      st_nxt = st_r;
      if (clr_go) begin
         st_nxt.flags = st_r.flags & ~clr_bits;
      end
      st_nxt.flags = st_nxt.flags | (events & event_enable_mask);
      if (!rst_n) begin
         st_nxt.flags = psi_pkg::FLAGS_RST;
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      st_r <= st_nxt;
   end

   assign flags_r   = st_r.flags;
   assign flags_nxt = st_nxt.flags;

endmodule : psi_flag_bank

// file: core/psi_pin_drive.sv
// one event pin: or of routed, enabled flags
`timescale 1ns/1ps
module psi_pin_drive (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // flags and masks
   input  wire logic [15:0] flags_nxt,
   input  wire logic [15:0] event_enable_mask,
   input  wire logic [15:0] pin_mask,
   // pin level
   output logic             pin_r
);

   typedef struct packed {
      logic pin;
   } psi_pin_s;

   psi_pin_s st_r;
   psi_pin_s st_nxt;

   // pin follows the next flags so it rises with the logged flag
   always_comb begin
      st_nxt.pin = |(flags_nxt & pin_mask & event_enable_mask);
      if (!rst_n) begin
         st_nxt.pin = 1'b0;
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      st_r <= st_nxt;
   end

   assign pin_r = st_r.pin;

endmodule : psi_pin_drive

// file: tb/psi_status_irq_assertions.sv
// checker for packet status bytes, signal level and event flags
`timescale 1ns/1ps
module psi_status_irq_assertions (
   // clock, reset and command port
   input wire logic                sys_clk, rst_n, frame_start, cmd_byte_valid,
   input wire logic [7:0]          cmd_byte, resp_byte_r,
   // radio and packet inputs
   input wire psi_pkg::psi_ptype_e packet_type,
   input wire logic                rx_active, packet_engine_busy, packet_tx_finished,
   input wire logic                transmit_finished_event, sample_strobe, event_pin_one,
   input wire logic signed [9:0]   power_half_dbm,
   // registered results
   input wire logic [7:0]          pkt_status_byte_r, pkt_error_byte_r, pkt_sync_byte_r,
   input wire logic [7:0]          instant_signal_level_r,
   input wire logic [15:0]         interrupt_flag_log_r
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // upper flag byte, compared two edges after the opcode
   logic [7:0] flag_hi;
   assign flag_hi = interrupt_flag_log_r[15:8];
   // frame start followed by the flag read opcode
   sequence s_read_op;
      frame_start ##1 cmd_byte_valid && cmd_byte == psi_pkg::OP_READ_EVENT_FLAGS;
   endsequence
   property p_read_hi; s_read_op ##1 cmd_byte_valid |=> resp_byte_r == $past(flag_hi, 2);
   endproperty
   a_read_hi: assert property (p_read_hi) else $error("flag read upper byte wrong");
   property p_busy; packet_engine_busy |=> pkt_error_byte_r[0]; endproperty
   a_busy: assert property (p_busy) else $error("busy bit not mirrored");
   property p_tx; packet_tx_finished && !rx_active |=> pkt_status_byte_r[0]; endproperty
   a_tx: assert property (p_tx) else $error("tx finished bit missing");
   property p_reserved; (pkt_status_byte_r & 8'hDE) == 8'h00 && !pkt_error_byte_r[7]
      && pkt_sync_byte_r[7:3] == 5'h00 && $onehot0(pkt_sync_byte_r[2:0]); endproperty
   a_reserved: assert property (p_reserved) else $error("reserved or sync code bad");
   property p_rose; $rose(interrupt_flag_log_r[0]) |-> $past(transmit_finished_event);
   endproperty
   a_rose: assert property (p_rose) else $error("flag set without event");
   property p_fell; $fell(interrupt_flag_log_r[14]) && $past(rst_n) |-> $past(cmd_byte_valid);
   endproperty
   a_fell: assert property (p_fell) else $error("flag dropped without clear");
   property p_pin; event_pin_one |-> interrupt_flag_log_r != 16'h0000; endproperty
   a_pin: assert property (p_pin) else $error("pin high with no flag");
   property p_level; sample_strobe && packet_type == psi_pkg::PSI_PT_GFSK && power_half_dbm <= 0
      && power_half_dbm >= -255 |=> instant_signal_level_r == 8'(-$past(power_half_dbm));
   endproperty
   a_level: assert property (p_level) else $error("level byte wrong");
endmodule : psi_status_irq_assertions
bind psi_status_irq psi_status_irq_assertions u_chk (.*);

// file: tb/psi_host_model.sv
// host side: sends command frames and keeps the answer of each position
`timescale 1ns/1ps
module psi_host_model (
   // clock and answers
   input  wire logic       sys_clk,
   input  wire logic [7:0] resp_byte_r,
   // command port
   output logic            frame_start,
   output logic            cmd_byte_valid,
   output logic [7:0]      cmd_byte
);
   logic [7:0] rx [16];
   // idle port
   initial begin
      frame_start = 1'b0;
      cmd_byte_valid = 1'b0;
      cmd_byte = 8'h00;
   end
   // start pulse, then bytes back to back; released byte lines show the inverse
   task automatic xfer(input logic [7:0] tx [$]);
      @(posedge sys_clk) #5 frame_start = 1'b1;
      for (int k = 0; k < tx.size(); k++) begin
         @(posedge sys_clk) #5 rx[k] = resp_byte_r;
         frame_start = 1'b0;
         cmd_byte_valid = 1'b1;
         cmd_byte = tx[k];
      end
      @(posedge sys_clk) #5 cmd_byte_valid = 1'b0;
      cmd_byte = ~cmd_byte;
   endtask : xfer
endmodule : psi_host_model

// file: tb/tb_top.sv
// self-checking bench for packet status and event flag logic
`timescale 1ns/1ps
module tb_top;
   logic sys_clk, rst_n, uart_mode, sample_strobe;
   logic [18:0] r;
   logic [16:0] evt;
   logic [23:0] ex;
   logic [15:0] m, flg;
   logic [15:0] avl [5];
   logic signed [9:0] power_half_dbm;
   psi_pkg::psi_ptype_e packet_type;
   wire logic frame_start, cmd_byte_valid, event_pin_one, event_pin_two, event_pin_three;
   wire logic [7:0] cmd_byte, resp_byte_r, instant_signal_level_r, pkt_status_byte_r,
      pkt_error_byte_r, pkt_sync_byte_r;
   wire logic [15:0] interrupt_flag_log_r;
   int num_errors, check_count, cyc, i, q;
   psi_host_model u_host (.*);
   psi_status_irq u_psi_status_irq (.*, .radio_status(8'h5A), .rx_active(r[0]),
      .dynamic_length(r[1]), .sync_detect_en(r[2]), .checksum_en(r[3]),
      .long_preamble_option(r[4]), .pkt_op_start(r[5]), .packet_engine_busy(r[6]),
      .packet_tx_finished(r[7]), .header_seen_flag(r[8]), .received_no_ack_bit(r[9]),
      .sync_result_strobe(r[10]), .oversize_length_fail(r[11]), .checksum_fail_flag(r[12]),
      .packet_aborted_flag(r[13]), .rx_finished_flag(r[14]), .symbol_strobe(r[15]),
      .matched_sync_index(r[18:16]), .transmit_finished_event(evt[0]),
      .receive_finished_event(evt[1]), .sync_match_event(evt[2]), .sync_mismatch_event(evt[3]),
      .header_ok_event(evt[4]), .header_bad_event(evt[5]), .checksum_bad_event(evt[6]),
      .responder_reply_finished(evt[7]), .responder_request_dropped(evt[8]),
      .ranging_result_event(evt[9]), .initiator_timed_out(evt[10]),
      .responder_request_ok(evt[11]), .activity_check_finished(evt[12]),
      .activity_found(evt[13]), .radio_op_timeout(evt[14]), .preamble_found_event(evt[15]),
      .advanced_ranging_event(evt[16]));
   // clock and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         final_report();
      end
   end
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // read flags over the port, then compare flags and pins with the model
   task automatic rdchk();
      u_host.xfer('{8'h15, {6'h00, uart_mode, 1'b0}, 8'h00, 8'h00});
      chk("flags", flg, {u_host.rx[2], u_host.rx[3]});
      chk("status", 16'h005A, 16'(u_host.rx[1]));
      chk("log", flg, interrupt_flag_log_r);
      chk("pins", 16'({|(flg & 16'h8000), |(flg & 16'h4002), flg[0]}),
         16'({event_pin_three, event_pin_two, event_pin_one}));
   endtask : rdchk
   task automatic clr(logic [15:0] c);
      if (uart_mode) u_host.xfer('{8'h97, 8'h02, c[15:8], c[7:0]});
      else u_host.xfer('{8'h97, c[15:8], c[7:0]});
      flg &= ~c;
   endtask : clr
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report
   // main sequence
   initial begin
      {uart_mode, sample_strobe, r, evt, power_half_dbm, flg, m, ex} = '0;
      packet_type = psi_pkg::PSI_PT_GFSK;
      avl = '{psi_pkg::AVAIL_GFSK, psi_pkg::AVAIL_CHIRP, psi_pkg::AVAIL_RANGING,
              psi_pkg::AVAIL_NBFS, psi_pkg::AVAIL_LE};
      rst_n = 1'b0;
      void'($urandom(58379));
      repeat (2) @(posedge sys_clk);
      #5 rst_n = 1'b1;
      rdchk();
      for (int t = 0; t < 5; t++) begin
         packet_type = psi_pkg::psi_ptype_e'(t);
         uart_mode = 1'b0;
         m = (t == 0) ? 16'hFFFF : 16'($urandom);
         u_host.xfer('{8'h8D, m[15:8], m[7:0], 8'h00, 8'h01, 8'h40, 8'h02, 8'h80, 8'h00});
         for (int k = 0; k < 17; k++) begin
            @(posedge sys_clk) #5 evt = 17'(1) << k;
            i = (k == 16) ? 15 : k;
            if (k < 15 || (k == 16) == (t == 2)) flg[i] = flg[i] | (m[i] & avl[t][i]);
         end
         @(posedge sys_clk) #5 evt = '0;
         uart_mode = t[0];
         rdchk();
         clr(16'($urandom));
         rdchk();
         clr(16'hFFFF);
         rdchk();
      end
      $display("test flags done");
      for (int j = 0; j < 4; j++) begin
         uart_mode = j[0];
         packet_type = j[1] ? psi_pkg::PSI_PT_CHIRP : psi_pkg::PSI_PT_GFSK;
         q = $urandom_range(255);
         @(posedge sys_clk) #5 power_half_dbm = 10'(-q);
         sample_strobe = ~j[1];
         r[15] = j[1];
         @(posedge sys_clk) #5 sample_strobe = 1'b0;
         r[15] = 1'b0;
         u_host.xfer('{8'h1F, {7'h00, uart_mode}, 8'h00});
         chk("level", 16'(q), 16'(u_host.rx[2]));
      end
      $display("test level done");
      // packet bytes against a model updated from the pulses of the step before
      repeat (300) begin
         @(posedge sys_clk) #5;
         chk("pstat", 16'(ex[23:16]), 16'(pkt_status_byte_r));
         chk("error", 16'(ex[15:8]), 16'(pkt_error_byte_r));
         chk("sync", 16'(ex[7:0]), 16'(pkt_sync_byte_r));
         r = 19'($urandom);
         packet_type = psi_pkg::psi_ptype_e'($urandom_range(4));
         if (r[5]) ex = '0;
         if (r[0] && r[1] && r[8]) {ex[21], ex[10]} = {r[9], 1'b1};
         if (!r[0] && r[7]) ex[16] = 1'b1;
         if (r[0] && r[2] && r[10]) {ex[14], ex[2:0]} = $onehot(r[18:16]) ? {1'b0, r[18:16]} : 4'h8;
         ex[13:11] |= {r[0] & r[1] & r[11], r[0] & r[3] & r[12], r[13]};
         ex[9:8] = {ex[9] | (r[0] & r[14]), r[6]};
      end
      r = '0;
      $display("test random done");
      final_report();
   end
endmodule : tb_top
